// File: core/dcc_top.sv
// Comparator control and status: config register, change flag, irq gating.
// Assumes a byte-wide core register bus with single-cycle rd/wr strobes.
//
// Contract
// - Two comparators fed from four pins, reference also selectable.
// - Config register at 1Fh: mode bits 2..0, input switch bit 3.
// - Bits 7,6 read comparator 2 and 1 results.
// - Modes 001/010: switch bit picks first inverting pin; 010 clear uses pin one.
// - Change flag, peripheral flag bit 6, sets on result change.
// - Flag cleared by writing 0; writing 1 sets it.
// - Request only when local, peripheral and global enables set.
// - Flag sets even with enables clear.
// - Change coinciding with config read may miss setting flag.
// - Mismatch keeps re-setting the flag.
// - Config read or write re-latches results, ending mismatch.
// - Comparators run in sleep; enabled change wakes the device.
// - Mode 111 turns both comparators off.
// - Wake from sleep leaves config register unchanged.
// - Reset returns config register to mode 000.
// - Comparators powered down during reset.
`timescale 1ns/10ps
module dcc_top (
    input wire logic mclk,
    input wire logic nrst,
    input dcc_pkg::dcc_bus_s bus,
    output logic [7:0] rdata,
    input wire logic first_comparator_result,
    input wire logic second_comparator_result,
    input wire logic sleeping,
    output dcc_pkg::dcc_route_s route,
    output logic irq_req,
    output logic wake_req
);
    logic [2:0] mode_q;
    logic switch_q;
    logic [1:0] live;
    logic [1:0] latched_q;
    logic flag_q;
    logic irq_en_q;
    logic periph_en_q;
    logic global_en_q;
    logic cfg_hit;
    logic mismatch;

    // Read-only-ish decode helper
    function automatic logic hit(input dcc_pkg::dcc_bus_s b, input logic [6:0] a);
        return (b.rd | b.wr) && (b.addr == a);
    endfunction

    dcc_sync #(
        .WIDTH(2)
    ) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din({second_comparator_result, first_comparator_result}),
        .dout(live)
    );

    dcc_route u_route (
        .comparator_mode_field(mode_q),
        .input_switch_select(switch_q),
        .in_reset(!nrst),
        .route(route)
    );

    assign cfg_hit = hit(bus, dcc_pkg::DCC_CFG_ADDR);
    assign mismatch = (live != latched_q);

    // Config register; sleep has no effect on it
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mode_q <= dcc_pkg::DCC_MODE_RESET;
            switch_q <= dcc_pkg::DCC_SWITCH_RESET;
        end else if (bus.wr && bus.addr == dcc_pkg::DCC_CFG_ADDR) begin
            mode_q <= bus.wdata[dcc_pkg::DCC_MODE_LSB +: 3];
            switch_q <= bus.wdata[dcc_pkg::DCC_SWITCH_BIT];
        end
    end

    // Latched copy of results, refreshed by any config access
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            latched_q <= 2'h0;
        end else if (cfg_hit) begin
            latched_q <= live;
        end
    end

    // Change flag: mismatch sets it every cycle unless a config access
    // lands on it, which reproduces the missed-set race on a read
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (mismatch && !cfg_hit) begin
            flag_q <= 1'b1;
        end else if (bus.wr && bus.addr == dcc_pkg::DCC_PFLAG_ADDR) begin
            flag_q <= bus.wdata[dcc_pkg::DCC_FLAG_BIT];
        end
    end

    // Enable bits
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq_en_q <= 1'b0;
            periph_en_q <= 1'b0;
            global_en_q <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == dcc_pkg::DCC_PEN_ADDR) begin
                irq_en_q <= bus.wdata[dcc_pkg::DCC_IRQ_EN_BIT];
            end
            if (bus.wr && bus.addr == dcc_pkg::DCC_CORE_IRQ_ADDR) begin
                periph_en_q <= bus.wdata[dcc_pkg::DCC_PERIPH_EN_BIT];
                global_en_q <= bus.wdata[dcc_pkg::DCC_GLOBAL_EN_BIT];
            end
        end
    end

    // Interrupt gating; wake needs only the local and peripheral enables
    assign irq_req = flag_q & irq_en_q & periph_en_q & global_en_q;
    assign wake_req = sleeping & flag_q & irq_en_q & periph_en_q;

    // Read data registered; unused and result-write bits ignored
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                dcc_pkg::DCC_CFG_ADDR:
                    rdata <= {live[1], live[0], 2'b00, switch_q, mode_q};
                dcc_pkg::DCC_PFLAG_ADDR:
                    rdata <= {1'b0, flag_q, 6'h00};
                dcc_pkg::DCC_PEN_ADDR:
                    rdata <= {1'b0, irq_en_q, 6'h00};
                dcc_pkg::DCC_CORE_IRQ_ADDR:
                    rdata <= {global_en_q, periph_en_q, 6'h00};
                default:
                    rdata <= 8'h00;
            endcase
        end
    end
endmodule // dcc_top

// File: core/dcc_pkg.sv
// Package for the dual comparator control block: offsets, field positions,
// reset values and the shared structs.
// Assumes a byte-wide data register bus of the processor core.
package dcc_pkg;

    // Register addresses in the core's data space
    localparam logic [6:0] DCC_CFG_ADDR = 7'h1f;
    localparam logic [6:0] DCC_PFLAG_ADDR = 7'h0c;
    localparam logic [6:0] DCC_PEN_ADDR = 7'h0d;
    localparam logic [6:0] DCC_CORE_IRQ_ADDR = 7'h0b;

    // Field positions
    localparam int DCC_MODE_LSB = 0;
    localparam int DCC_SWITCH_BIT = 3;
    localparam int DCC_FIRST_RES_BIT = 6;
    localparam int DCC_SECOND_RES_BIT = 7;
    localparam int DCC_FLAG_BIT = 6;
    localparam int DCC_IRQ_EN_BIT = 6;
    localparam int DCC_PERIPH_EN_BIT = 6;
    localparam int DCC_GLOBAL_EN_BIT = 7;

    // Reset values
    localparam logic [2:0] DCC_MODE_RESET = 3'h0;
    localparam logic DCC_SWITCH_RESET = 1'b0;

    // Mode codes named in the description
    localparam logic [2:0] DCC_MODE_ANALOG = 3'h0;
    localparam logic [2:0] DCC_MODE_SWITCHED = 3'h1;
    localparam logic [2:0] DCC_MODE_SWITCHED_PAIR = 3'h2;
    localparam logic [2:0] DCC_MODE_OFF = 3'h7;

    // Input sources for both inverting and non-inverting selects
    typedef enum logic [2:0] {
        DCC_SRC_PIN0,
        DCC_SRC_PIN1,
        DCC_SRC_PIN2,
        DCC_SRC_PIN3,
        DCC_SRC_VREF,
        DCC_SRC_NONE
    } dcc_src_e;

    // Analog front-end control bundle
    typedef struct packed {
        logic first_power;
        logic second_power;
        dcc_src_e first_inv_sel;
        dcc_src_e second_inv_sel;
        dcc_src_e first_noninv_sel;
        dcc_src_e second_noninv_sel;
        logic [3:0] pin_analog;
    } dcc_route_s;

    // Register bus request
    typedef struct packed {
        logic [6:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } dcc_bus_s;

endpackage

// File: core/dcc_route.sv
// Mode decoder: turns the mode field and input switch into mux selects.
// Assumes an analog front end driven by the selects it produces.
`timescale 1ns/10ps
module dcc_route (
    input wire logic [2:0] comparator_mode_field,
    input wire logic input_switch_select,
    input wire logic in_reset,
    output dcc_pkg::dcc_route_s route
);
    // Decode routing; modes without a described route stay configurable
    always_comb begin
        route.first_power = 1'b1;
        route.second_power = 1'b1;
        route.first_noninv_sel = dcc_pkg::DCC_SRC_PIN2;
        route.second_noninv_sel = dcc_pkg::DCC_SRC_PIN2;
        route.first_inv_sel = dcc_pkg::DCC_SRC_PIN0;
        route.second_inv_sel = dcc_pkg::DCC_SRC_PIN1;
        route.pin_analog = 4'hf;
        case (comparator_mode_field)
            dcc_pkg::DCC_MODE_ANALOG: begin
                route.first_power = 1'b0;
                route.second_power = 1'b0;
                route.first_inv_sel = dcc_pkg::DCC_SRC_NONE;
                route.second_inv_sel = dcc_pkg::DCC_SRC_NONE;
            end
            dcc_pkg::DCC_MODE_SWITCHED: begin
                route.first_inv_sel = input_switch_select ? dcc_pkg::DCC_SRC_PIN3
                                                          : dcc_pkg::DCC_SRC_PIN0;
            end
            dcc_pkg::DCC_MODE_SWITCHED_PAIR: begin
                route.first_noninv_sel = dcc_pkg::DCC_SRC_VREF;
                route.second_noninv_sel = dcc_pkg::DCC_SRC_VREF;
                route.first_inv_sel = input_switch_select ? dcc_pkg::DCC_SRC_PIN3
                                                          : dcc_pkg::DCC_SRC_PIN0;
                route.second_inv_sel = input_switch_select ? dcc_pkg::DCC_SRC_PIN2
                                                           : dcc_pkg::DCC_SRC_PIN1;
            end
            dcc_pkg::DCC_MODE_OFF: begin
                route.first_power = 1'b0;
                route.second_power = 1'b0;
                route.pin_analog = 4'h0;
            end
            default: begin
                // Undescribed modes: plain pin pairs, switch picks pin three
                route.first_inv_sel = input_switch_select ? dcc_pkg::DCC_SRC_PIN3
                                                          : dcc_pkg::DCC_SRC_PIN0;
            end
        endcase
        // Reset interval overrides both comparator powers
        if (in_reset) begin
            route.first_power = 1'b0;
            route.second_power = 1'b0;
        end
    end
endmodule // dcc_route

// File: core/dcc_sync.sv
// Two-stage synchroniser for the comparator result levels.
// Assumes results are asynchronous analog outputs.
`timescale 1ns/10ps
module dcc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // First stage read only by the second
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // dcc_sync

// File: sim/dcc_pins_model.sv
// Far-side model: the two analog comparator results.
// Assumes the bench sets the wanted levels; settling is prompt or slow.
`timescale 1ns/10ps
module dcc_pins_model (
    input wire logic [1:0] want,
    input wire logic slow,
    output logic first_comparator_result,
    output logic second_comparator_result
);
    // Results lag their inputs off any clock edge, as real comparators do;
    // the starting level is driven at once, so the results are never unknown
    always begin
        {second_comparator_result, first_comparator_result} = want;
        @(want);
        #(slow ? 37 : 3);
    end
endmodule // dcc_pins_model

// File: sim/dcc_top_props.sv
// Port checker for the comparator control block.
// Assumes the register map of dcc_pkg; bound from the bench.
`timescale 1ns/10ps
module dcc_top_props (
    input wire logic mclk,
    input wire logic nrst,
    input dcc_pkg::dcc_bus_s bus,
    input logic [7:0] rdata,
    input wire logic first_comparator_result,
    input wire logic second_comparator_result,
    input wire logic sleeping,
    input dcc_pkg::dcc_route_s route,
    input logic irq_req,
    input logic wake_req
);
    logic wr_cfg;
    // Config writes cause every routing change outside reset
    assign wr_cfg = bus.wr && bus.addr == 7'h1f;
    default clocking @(posedge mclk); endclocking
    a_reset_powered_down: assert property (
        !nrst |-> !route.first_power && !route.second_power) else $error("powered in reset");
    a_reset_analog_pins: assert property (
        !nrst |=> route.pin_analog == 4'hf) else $error("pins not analog");
    a_off_mode_unpowered: assert property (disable iff (!nrst)
        wr_cfg && bus.wdata[2:0] == 3'h7 |=> !route.first_power && !route.second_power)
        else $error("off mode powered");
    a_unused_bits_zero: assert property (disable iff (!nrst)
        bus.rd && bus.addr == 7'h1f |=> rdata[5:4] == 2'h0) else $error("bits 5:4 set");
    a_unmapped_reads_zero: assert property (disable iff (!nrst)
        bus.rd && !(bus.addr inside {7'h1f, 7'h0b, 7'h0c, 7'h0d}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_switch_first_route: assert property (disable iff (!nrst)
        wr_cfg && bus.wdata[2:0] == 3'h1 |=> route.first_inv_sel == ($past(bus.wdata[3]) ?
        dcc_pkg::DCC_SRC_PIN3 : dcc_pkg::DCC_SRC_PIN0)) else $error("first route wrong");
    a_pair_second_route: assert property (disable iff (!nrst)
        wr_cfg && bus.wdata[3:0] == 4'h2 |=> route.second_inv_sel == dcc_pkg::DCC_SRC_PIN1)
        else $error("second route wrong");
    a_wake_only_asleep: assert property (disable iff (!nrst)
        wake_req |-> sleeping) else $error("wake while awake");
endmodule // dcc_top_props

// File: sim/test_dual_comparator_control.sv
// Bench for the comparator control block, with a comparator pin model.
// Assumes the package register map and single-cycle bus strobes.
`timescale 1ns/10ps
module test_dual_comparator_control;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic sleeping = 1'b0;
    logic slow = 1'b0;
    logic [1:0] want = 2'h0;
    logic res1;
    logic res2;
    logic irq_req;
    logic wake_req;
    logic [7:0] rdata;
    dcc_pkg::dcc_bus_s bus = '0;
    dcc_pkg::dcc_route_s route;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int cfg_m = 0;
    int flag_m = 0;
    // Free-running 100 MHz clock
    always #5 mclk = ~mclk;
    dcc_pins_model u_pins (.want(want), .slow(slow), .first_comparator_result(res1),
        .second_comparator_result(res2));
    dcc_top DUT (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
        .first_comparator_result(res1), .second_comparator_result(res2),
        .sleeping(sleeping), .route(route), .irq_req(irq_req), .wake_req(wake_req));
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Whole run needs under two hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One strobe cycle, launched and dropped at falling edges
    task automatic access(input logic [6:0] a, input logic rd, input logic [7:0] d);
        @(negedge mclk);
        bus = '{addr: a, rd: rd, wr: !rd, wdata: d};
        @(negedge mclk);
        bus.rd = 1'b0;
        bus.wr = 1'b0;
    endtask
    // Expected read data; only bit 6 of the flag register is ours
    function automatic logic [7:0] model(input logic [6:0] a);
        case (a)
            7'h1f: return {want[1], want[0], 2'h0, cfg_m[3:0]};
            7'h0c: return {1'b0, flag_m[0], 6'h00};
            default: return 8'h00;
        endcase
    endfunction
    task automatic rd(input logic [6:0] a);
        access(a, 1'b1, 8'h00);
        check(rdata & (a == 7'h0c ? 8'h40 : 8'hff), model(a));
    endtask
    initial begin
        void'($urandom(75));
        repeat (3) @(posedge mclk);
        check({7'h00, route.first_power | route.second_power}, 8'h00);
        @(negedge mclk) nrst = 1'b1;
        check({4'h0, route.pin_analog}, 8'h0f);
        rd(7'h1f);
        rd(7'h33);
        // Every mode and switch value; random upper bits must not stick
        for (int m = 0; m < 16; m++) begin
            cfg_m = m;
            access(7'h1f, 1'b0, {4'($urandom), m[3:0]});
            rd(7'h1f);
            if (m[2:0] == 3'h7) check({7'h00, route.first_power | route.second_power}, 8'h00);
            if (m == 2) check({5'h00, route.second_inv_sel}, 8'h01);
        end
        cfg_m = 1;
        access(7'h1f, 1'b0, 8'h01);
        // A change sets the flag with enables clear; clearing sticks only after a re-latch
        want = 2'h1;
        repeat (8) @(negedge mclk);
        flag_m = 1;
        rd(7'h0c);
        access(7'h0c, 1'b0, 8'h00);
        rd(7'h0c);
        rd(7'h1f);
        flag_m = 0;
        access(7'h0c, 1'b0, 8'h00);
        rd(7'h0c);
        flag_m = 1;
        access(7'h0c, 1'b0, 8'h40);
        rd(7'h0c);
        // Every combination of the three enables
        for (int e = 0; e < 8; e++) begin
            access(7'h0d, 1'b0, {1'b0, e[0], 6'h00});
            access(7'h0b, 1'b0, {e[2:1], 6'h00});
            check({7'h00, irq_req}, {7'h00, e == 7});
        end
        // Slow change while asleep wakes the core, global enable off
        cfg_m = 10;
        access(7'h1f, 1'b0, 8'h0a);
        flag_m = 0;
        access(7'h0c, 1'b0, 8'h00);
        access(7'h0b, 1'b0, 8'h40);
        sleeping = 1'b1;
        slow = 1'b1;
        want = 2'h2;
        repeat (8) @(negedge mclk);
        check({7'h00, wake_req}, 8'h01);
        check({7'h00, irq_req}, 8'h00);
        sleeping = 1'b0;
        flag_m = 1;
        rd(7'h1f);
        rd(7'h0c);
        // A change that lands on a config read is lost; flag cleared first so a set would show
        flag_m = 0;
        access(7'h0c, 1'b0, 8'h00);
        slow = 1'b0;
        want = 2'h0;
        @(negedge mclk);
        rd(7'h1f);
        rd(7'h0c);
        // Reset in mid-run: powers drop, config returns to mode 000
        nrst = 1'b0;
        repeat (3) @(negedge mclk);
        check({7'h00, route.first_power | route.second_power}, 8'h00);
        nrst = 1'b1;
        cfg_m = 0;
        flag_m = 0;
        rd(7'h1f);
        rd(7'h0c);
        stop_test;
    end
endmodule // test_dual_comparator_control
bind dcc_top dcc_top_props u_props (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .first_comparator_result(first_comparator_result),
    .second_comparator_result(second_comparator_result), .sleeping(sleeping),
    .route(route), .irq_req(irq_req), .wake_req(wake_req));
